// ### rtl/release_counter.sv
// down counter timing one stretch of the reset sequence
// assumes a load pulse and a synchronous active-high reset
`timescale 1ns/10ps
module release_counter
  import reset_seq_pkg::*;
#(
  parameter int WIDTH = 22
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // status
  output logic done
);
  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      count_q <= '0;
    else if (load)
      count_q <= loadValue;
    else if (count_q != '0)
      count_q <= count_q - 1'b1;
  end

  assign done = (count_q == '0) && !load;
endmodule // release_counter

// ### rtl/reset_seq_defines.svh
// reset sequencer constants: field positions, reset values, timing
// assumes the includer provides `timescale where needed
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH
`define CLK_FREQ_HZ 25000000
`define POR_TIMEOUT_MS 100
// longest time not involved; least time rounds down (integer divide truncates)
`define POR_TIMEOUT_CYC ((`CLK_FREQ_HZ / 1000) * `POR_TIMEOUT_MS)
`define SRC_PIN_BIT 0
`define SRC_POR_BIT 1
`define SRC_MCLK_BIT 2
`define SRC_SW_BIT 3
`define SRC_WDOG_BIT 4
`define SRC_CMP_BIT 5
`define SRC_CNV_BIT 6
`define PORT_LATCH_RST 8'hff
`define PC_RST 16'h0000
`define OSC_SEL_INTERNAL 1'b0
`define OSC_DIV_2MHZ 3'h0
`define WDOG_INTERVAL_MAX 3'h7
`define PIN_RELEASE_CYC 12
`endif

// ### rtl/reset_seq_pkg.sv
// types shared by the reset sequencer
// assumes nothing beyond a SystemVerilog compiler
package reset_seq_pkg;
  typedef enum logic [1:0] {
    stRun,
    stPor,
    stHold,
    stRelease
  } seq_state_t;
  typedef struct packed {
    logic [15:0] pcInit;
    logic [7:0] portLatch;
    logic pullUpEn;
    logic oscSel;
    logic [2:0] oscDiv;
    logic wdogEnable;
    logic [2:0] wdogInterval;
  } core_init_t;
  typedef struct packed {
    logic pin;
    logic cnv;
    logic sw;
    logic cmp;
    logic mclk;
    logic wdog;
  } req_t;
endpackage

// ### rtl/reset_sequencer.sv
// central reset sequencer: gathers seven reset requests, holds the core,
// times the supply-monitor stretch and records the reset source
// assumes all inputs synchronous to clk; rst is the clock's own reset
//
// How it works
// RULE_01 - reset halts core, pins known, registers defaulted
// RULE_02 - interrupts and timers disabled during, after reset; code drops intTimerDisable with coreReset on exit
// RULE_03 - program counter cleared to zero on exit
// RULE_04 - internal data memory never touched by reset
// RULE_05 - stack pointer reinitialised by reset
// RULE_06 - port latches all ones, pull-ups enabled
// RULE_07 - supply or software power-on drives pin low
// RULE_08 - internal oscillator at 2MHz selected after reset
// RULE_09 - watchdog enabled with longest interval on exit
// RULE_10 - seven requesters enter the reset state
// RULE_11 - hold reset while supply below threshold
// RULE_12 - pin held low for 100ms timeout
// RULE_13 - power-on exit sets power-on flag
// RULE_14 - other flags undefined after power-on
// RULE_15 - non-power-on reset clears power-on flag
// RULE_16 - software must treat memory invalid after power-on
// RULE_17 - software write of one forces power-on
// RULE_18 - later supply dip re-enters, exits as power-on
// RULE_19 - release synchronised so all leave together
`include "reset_seq_defines.svh"
`timescale 1ns/10ps
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int POR_CYCLES = `POR_TIMEOUT_CYC,
  parameter int PIN_CYCLES = `PIN_RELEASE_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // supply monitor and reset pin
  input wire logic supplyLow,
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // other requesters
  input wire logic cnvStrobeN,
  input wire logic cnvResetEn,
  input wire logic cmpOutN,
  input wire logic cmpResetEn,
  input wire logic missingClock,
  input wire logic wdogOverflow,
  input wire logic swPorWrite,
  // core side
  output logic coreReset,
  output logic intTimerDisable,
  output logic spReinit,
  output core_init_t coreInit,
  output logic [7:0] resetSource
);
  localparam int CW = 23;

  seq_state_t state_q;
  logic porPending_q;
  logic [7:0] source_q;
  req_t req;
  req_t latched_q;
  logic anyReq;
  logic cntLoad;
  logic [CW-1:0] cntValue;
  logic cntDone;
  logic porKick_q;
  logic otherReset_q;
  logic [CW-1:0] porAge_q;
  logic [CW-1:0] reqGap_q;

  // the pin output itself is one of our own sources, so ignore it while we drive
  assign req.pin = !rstPinIn && !rstPinOe; // RULE_10
  assign req.cnv = cnvResetEn && !cnvStrobeN; // RULE_10
  assign req.cmp = cmpResetEn && !cmpOutN; // RULE_10
  assign req.sw = 1'b0;
  assign req.mclk = missingClock; // RULE_10
  assign req.wdog = wdogOverflow; // RULE_10
  assign anyReq = req.pin | req.cnv | req.cmp | req.mclk | req.wdog;

  release_counter #(
    .WIDTH(CW)
  ) u_release (
    .clk(clk),
    .rst(rst),
    .load(cntLoad),
    .loadValue(cntValue),
    .done(cntDone)
  );

  // power-on path has priority: supply dip or software write restarts it
  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= stPor;
    else if (supplyLow || swPorWrite) // RULE_11 RULE_17 RULE_18
      state_q <= stPor;
    else
    begin
      unique case (state_q)
        stRun:
          if (anyReq)
            state_q <= stHold;
        stPor:
          if (cntDone)
            state_q <= stRelease; // RULE_12
        stHold:
          if (!anyReq)
            state_q <= stRelease;
        stRelease:
          if (anyReq)
            state_q <= stHold;
          else if (cntDone)
            state_q <= stRun; // RULE_19
      endcase
    end
  end

  // counter: 100ms for power-on, pin release minimum otherwise
  always_comb
  begin
    cntLoad = 1'b0;
    cntValue = '0;
    if (porKick_q || supplyLow || swPorWrite || (state_q == stRun && anyReq) || (state_q == stRelease && anyReq))
    begin
      cntLoad = 1'b1;
      cntValue = (porKick_q || supplyLow || swPorWrite) ? CW'(POR_CYCLES) : CW'(PIN_CYCLES); // RULE_12
    end
    else if (state_q == stHold)
    begin
      cntLoad = 1'b1;
      cntValue = CW'(PIN_CYCLES);
    end
  end

  // counter is cleared under rst, so the first power-on stretch loads one cycle after it
  always_ff @(posedge clk)
  begin
    if (rst)
      porKick_q <= 1'b1; // RULE_12
    else
      porKick_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      porPending_q <= 1'b1;
    else if (supplyLow || swPorWrite)
      porPending_q <= 1'b1;
    else if (state_q == stRun)
      porPending_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      latched_q <= '0;
    else if (state_q == stRun && !anyReq)
      latched_q <= '0;
    else
      latched_q <= latched_q | req;
  end

  // only flags the source; other bits left zero, software treats them as undefined after power-on
  always_ff @(posedge clk)
  begin
    if (rst)
      source_q <= 8'h02;
    else if (state_q == stRelease && cntDone && !anyReq && !supplyLow && !swPorWrite)
    begin
      source_q <= '0;
      if (porPending_q)
        source_q[`SRC_POR_BIT] <= 1'b1; // RULE_13 RULE_14
      else
      begin
        source_q[`SRC_POR_BIT] <= 1'b0; // RULE_15
        source_q[`SRC_PIN_BIT] <= latched_q.pin;
        source_q[`SRC_MCLK_BIT] <= latched_q.mclk;
        source_q[`SRC_WDOG_BIT] <= latched_q.wdog;
        source_q[`SRC_CMP_BIT] <= latched_q.cmp;
        source_q[`SRC_CNV_BIT] <= latched_q.cnv;
      end
    end
  end

  assign resetSource = source_q;
  // one registered state, so every register leaves reset on the same edge
  assign coreReset = (state_q != stRun); // RULE_01 RULE_19
  assign intTimerDisable = coreReset; // RULE_02
  assign spReinit = coreReset; // RULE_04 RULE_05
  // data memory has no reset path from here
  assign rstPinOe = (state_q == stPor); // RULE_07 RULE_12
  assign rstPinOut = 1'b0;

  always_comb
  begin
    coreInit.pcInit = `PC_RST; // RULE_03
    coreInit.portLatch = `PORT_LATCH_RST; // RULE_06
    coreInit.pullUpEn = 1'b1; // RULE_06
    coreInit.oscSel = `OSC_SEL_INTERNAL; // RULE_08
    coreInit.oscDiv = `OSC_DIV_2MHZ; // RULE_08
    coreInit.wdogEnable = 1'b1; // RULE_09
    coreInit.wdogInterval = `WDOG_INTERVAL_MAX; // RULE_09
  end

  property p_supply_hold;
    @(posedge clk) disable iff (rst) supplyLow |=> coreReset && rstPinOe;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("supply low did not hold reset"); // RULE_11

  property p_sw_por;
    @(posedge clk) disable iff (rst) swPorWrite |=> state_q == stPor;
  endproperty
  a_sw_por: assert property (p_sw_por) else $error("software power-on not entered"); // RULE_17

  property p_pin_low_por;
    @(posedge clk) disable iff (rst) rstPinOe |-> state_q == stPor && !rstPinOut;
  endproperty
  a_pin_low_por: assert property (p_pin_low_por) else $error("pin driven outside power-on"); // RULE_07

  sequence s_leave_por;
    state_q == stPor ##1 state_q == stRelease;
  endsequence
  property p_por_flag;
    @(posedge clk) disable iff (rst) s_leave_por ##1 (state_q == stRun) [*1] |-> resetSource[`SRC_POR_BIT];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag not set"); // RULE_13

  property p_other_clears;
    @(posedge clk) disable iff (rst) $rose(state_q == stRun) && otherReset_q
      |-> !resetSource[`SRC_POR_BIT];
  endproperty
  a_other_clears: assert property (p_other_clears) else $error("power-on flag not cleared"); // RULE_15

  property p_req_enters;
    @(posedge clk) disable iff (rst) (state_q == stRun && anyReq) |=> coreReset;
  endproperty
  a_req_enters: assert property (p_req_enters) else $error("request did not enter reset"); // RULE_10

  property p_timers_off;
    @(posedge clk) disable iff (rst) coreReset |-> intTimerDisable && spReinit;
  endproperty
  a_timers_off: assert property (p_timers_off) else $error("timers not disabled in reset"); // RULE_02

  property p_exit_defaults;
    @(posedge clk) disable iff (rst) $fell(coreReset) |-> coreInit.pcInit == 16'h0000
      && coreInit.wdogInterval == 3'h7 && coreInit.portLatch == 8'hff;
  endproperty
  a_exit_defaults: assert property (p_exit_defaults) else $error("exit defaults wrong"); // RULE_03

  // checker helpers: cycles since the last power-on cause and since the last request
  always_ff @(posedge clk)
  begin
    if (rst || supplyLow || swPorWrite)
      porAge_q <= '0;
    else if (porAge_q != '1)
      porAge_q <= porAge_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || supplyLow || swPorWrite || anyReq)
      reqGap_q <= '0;
    else if (reqGap_q != '1)
      reqGap_q <= reqGap_q + 1'b1;
  end

  // remembers that the pending exit is not a power-on one
  always_ff @(posedge clk)
  begin
    if (rst || supplyLow || swPorWrite)
      otherReset_q <= 1'b0;
    else if (state_q == stRun && anyReq)
      otherReset_q <= 1'b1;
  end

  property p_por_length;
    @(posedge clk) disable iff (rst) s_leave_por |-> porAge_q >= CW'(POR_CYCLES);
  endproperty
  a_por_length: assert property (p_por_length) else $error("power-on stretch too short"); // RULE_12

  property p_release_gap;
    @(posedge clk) disable iff (rst) $fell(coreReset) |-> reqGap_q >= CW'(PIN_CYCLES);
  endproperty
  a_release_gap: assert property (p_release_gap) else $error("reset left too soon after request"); // RULE_10

  property p_source_stable;
    @(posedge clk) disable iff (rst) state_q == stRun && $past(state_q) == stRun |-> $stable(resetSource);
  endproperty
  a_source_stable: assert property (p_source_stable) else $error("source changed while running"); // RULE_13

  property p_dip_restarts;
    @(posedge clk) disable iff (rst) supplyLow && state_q != stPor |=> state_q == stPor && rstPinOe;
  endproperty
  a_dip_restarts: assert property (p_dip_restarts) else $error("supply dip did not restart power-on"); // RULE_18

  property p_quiet_run;
    @(posedge clk) disable iff (rst) state_q == stRun && !anyReq && !supplyLow && !swPorWrite |=> !coreReset;
  endproperty
  a_quiet_run: assert property (p_quiet_run) else $error("reset entered with no requester"); // RULE_10

  property p_exit_on_done;
    @(posedge clk) disable iff (rst) state_q == stRelease && cntDone && !anyReq && !supplyLow && !swPorWrite
      |=> !coreReset && !rstPinOe;
  endproperty
  a_exit_on_done: assert property (p_exit_on_done) else $error("release did not end on time"); // RULE_19

  property p_first_load;
    @(posedge clk) disable iff (rst) porKick_q |-> cntLoad && cntValue == CW'(POR_CYCLES);
  endproperty
  a_first_load: assert property (p_first_load) else $error("power-on stretch not loaded"); // RULE_12

  property p_single_exit;
    @(posedge clk) disable iff (rst) $fell(coreReset) |-> $past(state_q) == stRelease;
  endproperty
  a_single_exit: assert property (p_single_exit) else $error("reset left outside release"); // RULE_19

  property p_por_only_flag;
    @(posedge clk) disable iff (rst) s_leave_por ##1 state_q == stRun |-> resetSource == 8'h02;
  endproperty
  a_por_only_flag: assert property (p_por_only_flag) else $error("other flags set after power-on"); // RULE_14

  property p_sw_drives_pin;
    @(posedge clk) disable iff (rst) swPorWrite |=> rstPinOe && !rstPinOut && coreReset;
  endproperty
  a_sw_drives_pin: assert property (p_sw_drives_pin) else $error("software power-on left pin free"); // RULE_07

  property p_req_holds;
    @(posedge clk) disable iff (rst) state_q != stRun && anyReq |=> coreReset;
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("request did not hold reset"); // RULE_10

  sequence s_leave_hold;
    state_q == stHold ##1 state_q == stRelease;
  endsequence
  property p_hold_reload;
    @(posedge clk) disable iff (rst) s_leave_hold |-> !cntDone && coreReset;
  endproperty
  a_hold_reload: assert property (p_hold_reload) else $error("release stretch not reloaded"); // RULE_10

  property p_exit_clock;
    @(posedge clk) disable iff (rst) $fell(coreReset)
      |-> coreInit.oscSel == 1'b0 && coreInit.oscDiv == 3'h0 && coreInit.pullUpEn;
  endproperty
  a_exit_clock: assert property (p_exit_clock) else $error("exit clock or pull-ups wrong"); // RULE_08
endmodule // reset_sequencer

// ### tb/reset_sequencer_tb_top.sv
// bench for the reset sequencer: power-on, each requester, forced and dip
// assumes short counts POR_C and PIN_C so the run stays brief
`timescale 1ns/10ps
module reset_sequencer_tb_top;
  import reset_seq_pkg::*;
  localparam int POR_C = 20;
  localparam int PIN_C = 12;
  logic clk = 0, rst = 1, supplyReq = 0, pinLow = 0, swPor = 0;
  logic cnvN = 1, cnvEn = 1, cmpN = 1, cmpEn = 1, mclk = 0, wdog = 0;
  logic supplyLow, rstPinIn, rstPinOut, rstPinOe, coreReset, intTimerDisable, spReinit;
  core_init_t coreInit;
  logic [7:0] resetSource;
  int fails = 0, tests_run = 0, cycles = 0, n;
  logic [7:0] srcExp [5] = '{8'h01, 8'h40, 8'h20, 8'h04, 8'h10};

  reset_sequencer #(.POR_CYCLES(POR_C), .PIN_CYCLES(PIN_C)) dut_u (.clk(clk), .rst(rst),
    .supplyLow(supplyLow), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .cnvStrobeN(cnvN), .cnvResetEn(cnvEn), .cmpOutN(cmpN), .cmpResetEn(cmpEn),
    .missingClock(mclk), .wdogOverflow(wdog), .swPorWrite(swPor), .coreReset(coreReset),
    .intTimerDisable(intTimerDisable), .spReinit(spReinit), .coreInit(coreInit),
    .resetSource(resetSource));
  supply_pin_model model_u (.clk(clk), .supplyReq(supplyReq), .pinLow(pinLow),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .supplyLow(supplyLow), .rstPinIn(rstPinIn));

  initial forever #20 clk = ~clk;
  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_release(output int cyc);
    cyc = 0;
    while (coreReset !== 1'b0 && cyc < 300)
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask

  task automatic set_req(input int k, input logic on);
    case (k)
      0: pinLow <= on;
      1: cnvN <= !on;
      2: cmpN <= !on;
      3: mclk <= on;
      default: wdog <= on;
    endcase
  endtask

  task automatic por_exit();
    check("core held", coreReset, 1);
    check("pin driven", rstPinOe, 1);
    check("pin level", rstPinIn, 0);
    check("int off", intTimerDisable, 1);
    check("sp reinit", spReinit, 1);
    wait_release(n);
    check("por length", 16'(n >= POR_C), 1);
    check("source", resetSource, 8'h02);
    check("pin free", rstPinOe, 0);
    check("int after", intTimerDisable, 0);
  endtask

  task automatic power_on();
    @(posedge clk);
    #1;
    por_exit();
    check("pc", coreInit.pcInit, 16'h0000);
    check("latch", coreInit.portLatch, 8'hff);
    check("pullup", coreInit.pullUpEn, 1);
    check("osc", {coreInit.oscSel, coreInit.oscDiv}, 0);
    check("wdog", {coreInit.wdogEnable, coreInit.wdogInterval}, 4'hf);
  endtask

  task automatic each_source();
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk);
      set_req(k, 1);
      repeat (3) @(posedge clk);
      #1;
      check("held", coreReset, 1);
      check("no drive", rstPinOe, 0);
      @(posedge clk);
      set_req(k, 0);
      wait_release(n);
      check("stretch", 16'(n >= PIN_C), 1);
      check("source", resetSource, srcExp[k]);
    end
    // strobe and comparator ignored while not enabled
    @(posedge clk);
    {cnvEn, cmpEn, cnvN, cmpN} <= 4'h0;
    repeat (4) @(posedge clk);
    #1;
    check("gated", coreReset, 0);
    @(posedge clk);
    {cnvEn, cmpEn, cnvN, cmpN} <= 4'hf;
  endtask

  // second request arriving during the release stretch restarts the hold
  task automatic restart();
    @(posedge clk);
    mclk <= 1;
    @(posedge clk);
    mclk <= 0;
    repeat (5) @(posedge clk);
    wdog <= 1;
    @(posedge clk);
    wdog <= 0;
    wait_release(n);
    check("restart stretch", 16'(n >= PIN_C), 1);
    check("restart source", resetSource, 8'h14);
  endtask

  task automatic sw_force();
    @(posedge clk);
    swPor <= 1;
    @(posedge clk);
    swPor <= 0;
    @(posedge clk);
    #1;
    por_exit();
  endtask

  task automatic supply_dip();
    @(posedge clk);
    supplyReq <= 1;
    repeat (40) @(posedge clk);
    #1;
    check("dip held", coreReset, 1);
    @(posedge clk);
    supplyReq <= 0;
    @(posedge clk);
    #1;
    por_exit();
    check("memory invalid flag", resetSource[1], 1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    power_on();
    each_source();
    restart();
    sw_force();
    supply_dip();
    report_and_stop();
  end
endmodule // reset_sequencer_tb_top

// ### tb/supply_pin_model.sv
// partner: supply monitor and the reset pin with its weak pull-up
// assumes the sequencer drives the pin only while rstPinOe is high
`timescale 1ns/10ps
module supply_pin_model
(
  // clock
  input wire logic clk,
  // bench controls
  input wire logic supplyReq,
  input wire logic pinLow,
  // pin and monitor
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  output logic supplyLow,
  output logic rstPinIn
);
  // a released pin floats high through the pull-up
  assign rstPinIn = rstPinOe ? rstPinOut : !pinLow;
  always_ff @(posedge clk)
  begin
    supplyLow <= supplyReq;
  end
endmodule // supply_pin_model
